// ---- sdp_pkg.sv ----
// Operation
// - Match0 full compare uses all 24 bits.
// - Ignore-low option compares address bits 23..8.
// - Single-step breaks after every completed instruction.
// - Forced reset bit self-clears when reset ends.
// - Master control write wakes halt or sleep.
// - Staging bytes at 13h-15h hold write data.
// - Short operands come from low staging bytes.
// - Command register sits at 16h after staging.
// - Command write executes at once.
// - Codes 00-05 read register groups upper first.
// - Codes 80-85 load groups from staging bytes.
// - SP access follows long-address mode.
// - Code 07/87 read or load program counter.
// - 08 sets, 09 clears long mode; 88-8A reserved.
// - Code 0A exchanges main and alternate pairs.
// - 0B/8B access memory at PC, then increment.
// - Break control write-only, resets to zero.
`default_nettype none
package sdp_pkg;
  // Debug register addresses.
  localparam logic [7:0] ADDR_MATCH0_LOW   = 8'h00;
  localparam logic [7:0] ADDR_MATCH0_HIGH  = 8'h01;
  localparam logic [7:0] ADDR_MATCH0_UPPER = 8'h02;
  localparam logic [7:0] ADDR_BREAK_CTL    = 8'h10;
  localparam logic [7:0] ADDR_MASTER_CTL   = 8'h11;
  localparam logic [7:0] ADDR_STAGE_UPPER  = 8'h13;
  localparam logic [7:0] ADDR_STAGE_HIGH   = 8'h14;
  localparam logic [7:0] ADDR_STAGE_LOW    = 8'h15;
  localparam logic [7:0] ADDR_COMMAND      = 8'h16;
  // Break control field positions.
  localparam int BRK_NEXT_BIT   = 7;
  localparam int BRK_MATCH0_BIT = 3;
  localparam int BRK_IGNLO0_BIT = 1;
  localparam int BRK_STEP_BIT   = 0;
  localparam logic [7:0] BREAK_CTL_RESET = 8'h00;
  // Master control field position.
  localparam int MASTER_RESET_BIT = 7;
  // Command coding: bit 7 selects write, low bits the operation.
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [6:0] OP_LAST_GROUP = 7'h07;
  localparam logic [6:0] OP_SP         = 7'h06;
  localparam logic [6:0] OP_LONG_SET   = 7'h08;
  localparam logic [6:0] OP_LONG_CLR   = 7'h09;
  localparam logic [6:0] OP_EXCHANGE   = 7'h0A;
  localparam logic [6:0] OP_MEMORY     = 7'h0B;
  // Register group selects seen by the core.
  localparam logic [3:0] GRP_SP_SHORT  = 4'h8;
  localparam int ADDR_W = 24;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RDREG,
    ST_MEM
  } sdp_state_e;
endpackage : sdp_pkg
`default_nettype wire

// ---- sdp_wr_if.sv ----
`default_nettype none
// Carries one decoded debug-link register write into the system domain.
interface sdp_wr_if;
  logic       wr_stb;  // One-cycle write pulse in the system domain.
  logic [7:0] addr;    // Register address, stable while pulsed.
  logic [7:0] data;    // Write data, stable while pulsed.
  modport src (output wr_stb, output addr, output data);
  modport dst (input wr_stb, input addr, input data);
endinterface : sdp_wr_if
`default_nettype wire

// ---- sdp_wr_cdc.sv ----
`default_nettype none
// Moves register writes from the link clock to the system clock with a
// toggle handshake; the held address and data do not move while pending.
module sdp_wr_cdc (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       lnk_clk_i,
  input  wire logic       lnk_rst_i,
  input  wire logic       lnk_wr_i,
  input  wire logic [7:0] lnk_addr_i,
  input  wire logic [7:0] lnk_data_i,
  output logic            lnk_ready_o,
  sdp_wr_if.src           wr
);
  import sdp_pkg::*;
  logic       req_tgl_reg;   // Link side request toggle.
  logic [7:0] hold_addr_reg; // Link side held address.
  logic [7:0] hold_data_reg; // Link side held data.
  logic [1:0] ack_sync_reg;  // Acknowledge toggle synchroniser.
  logic [1:0] req_sync_reg;  // Request toggle synchroniser.
  logic       req_seen_reg;  // Last request toggle acted on.
  logic       ack_tgl_reg;   // System side acknowledge toggle.
  logic       take_lnk;      // Link write accepted this cycle.
  logic       new_req;       // Fresh request seen in system domain.

  // Link is free once the acknowledge has come back around.
  assign lnk_ready_o = (req_tgl_reg == ack_sync_reg[1]);
  assign take_lnk    = lnk_wr_i && lnk_ready_o;
  assign new_req     = (req_sync_reg[1] != req_seen_reg);

  // Link domain: capture a write and flip the request.
  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst_i) begin
      req_tgl_reg   <= 1'b0;
      hold_addr_reg <= 8'h00;
      hold_data_reg <= 8'h00;
      ack_sync_reg  <= 2'b00;
    end else begin
      ack_sync_reg <= {ack_sync_reg[0], ack_tgl_reg};
      if (take_lnk) begin
        req_tgl_reg   <= ~req_tgl_reg;
        hold_addr_reg <= lnk_addr_i;
        hold_data_reg <= lnk_data_i;
      end
    end
  end

  // System domain: detect the flip, pulse once and acknowledge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_sync_reg <= 2'b00;
      req_seen_reg <= 1'b0;
      ack_tgl_reg  <= 1'b0;
      wr.wr_stb    <= 1'b0;
    end else begin
      req_sync_reg <= {req_sync_reg[0], req_tgl_reg};
      req_seen_reg <= req_sync_reg[1];
      wr.wr_stb    <= new_req;
      if (new_req) begin
        ack_tgl_reg <= ~ack_tgl_reg;
      end
    end
  end

  // Held words are stable from the toggle until acknowledge returns.
  assign wr.addr = hold_addr_reg;
  assign wr.data = hold_data_reg;
endmodule : sdp_wr_cdc
`default_nettype wire

// ---- sdp_access_ctl.sv ----
`default_nettype none
// Write-only control part of the serial debug port: break logic, forced
// reset, wake-up, write staging and the processor access command.
module sdp_access_ctl (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     lnk_clk_i,
  input  wire logic                     lnk_rst_i,
  input  wire logic                     lnk_wr_i,
  input  wire logic [7:0]               lnk_addr_i,
  input  wire logic [7:0]               lnk_data_i,
  output logic                          lnk_ready_o,
  input  wire logic [sdp_pkg::ADDR_W-1:0] cpu_insn_addr_i,
  input  wire logic                     cpu_insn_done_i,
  input  wire logic                     cpu_long_mode_i,
  input  wire logic                     cpu_reset_done_i,
  output logic                          break_o,
  output logic                          force_reset_o,
  output logic                          wake_o,
  output logic [3:0]                    reg_sel_o,
  output logic                          reg_wr_o,
  output logic [23:0]                   reg_wdata_o,
  input  wire logic [23:0]              reg_rdata_i,
  output logic                          long_mode_set_o,
  output logic                          long_mode_clr_o,
  output logic                          exchange_o,
  output logic                          mem_rd_o,
  output logic                          mem_wr_o,
  output logic [7:0]                    mem_wdata_o,
  input  wire logic                     mem_done_i,
  input  wire logic [7:0]               mem_rdata_i,
  output logic                          pc_inc_o,
  output logic [23:0]                   read_result_o,
  output logic                          cmd_busy_o
);
  import sdp_pkg::*;

  sdp_wr_if wr ();  // Write pulses already in the system domain.

  // Crossing from the link clock; no read path exists at all, so reads
  // of these addresses can neither return contents nor disturb state.
  sdp_wr_cdc u_cdc (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .lnk_clk_i   (lnk_clk_i),
    .lnk_rst_i   (lnk_rst_i),
    .lnk_wr_i    (lnk_wr_i),
    .lnk_addr_i  (lnk_addr_i),
    .lnk_data_i  (lnk_data_i),
    .lnk_ready_o (lnk_ready_o),
    .wr          (wr.src)
  );

  // Stored control state.
  logic [7:0]  break_ctl_reg;   // Break control byte.
  logic [23:0] match0_reg;      // Match 0 address, upper..low.
  logic [23:0] stage_reg;       // Write staging, upper..low.
  logic        force_reset_reg; // Forced reset request bit.
  logic        wake_reg;        // Wake pulse.
  sdp_state_e  state_reg;       // Command sequencer state.
  sdp_state_e  state_next;      // Next sequencer state.
  logic [3:0]  sel_reg;         // Group select held for the core.
  logic        reg_wr_reg;      // Group load pulse.
  logic        set_reg;         // Long mode set pulse.
  logic        clr_reg;         // Long mode clear pulse.
  logic        xchg_reg;        // Exchange pulse.
  logic        mem_rd_reg;      // Memory read start pulse.
  logic        mem_wr_reg;      // Memory write start pulse.
  logic        pc_inc_reg;      // Program counter step pulse.
  logic [23:0] result_reg;      // Read result, upper..low.

  // Address decode of the incoming write.
  logic wr_brk;    // Break control written.
  logic wr_mst;    // Master control written.
  logic wr_m0u;    // Match 0 upper written.
  logic wr_m0h;    // Match 0 high written.
  logic wr_m0l;    // Match 0 low written.
  logic wr_stu;    // Staging upper written.
  logic wr_sth;    // Staging high written.
  logic wr_stl;    // Staging low written.
  logic wr_cmd;    // Command written.
  assign wr_brk = wr.wr_stb && (wr.addr == ADDR_BREAK_CTL);
  assign wr_mst = wr.wr_stb && (wr.addr == ADDR_MASTER_CTL);
  assign wr_m0u = wr.wr_stb && (wr.addr == ADDR_MATCH0_UPPER);
  assign wr_m0h = wr.wr_stb && (wr.addr == ADDR_MATCH0_HIGH);
  assign wr_m0l = wr.wr_stb && (wr.addr == ADDR_MATCH0_LOW);
  assign wr_stu = wr.wr_stb && (wr.addr == ADDR_STAGE_UPPER);
  assign wr_sth = wr.wr_stb && (wr.addr == ADDR_STAGE_HIGH);
  assign wr_stl = wr.wr_stb && (wr.addr == ADDR_STAGE_LOW);
  // The command byte sits just above the staging bytes, so one
  // auto-incrementing burst lands data then command.
  assign wr_cmd = wr.wr_stb && (wr.addr == ADDR_COMMAND);

  // Break detection at instruction boundaries.
  logic hit_full;  // All address bits equal match 0.
  logic hit_page;  // Upper two bytes equal match 0.
  logic hit0;      // Match 0 break condition.
  logic step_hit;  // Single-step break condition.
  logic brk_event; // Hardware break this cycle.
  assign hit_full = (cpu_insn_addr_i == match0_reg);
  assign hit_page = (cpu_insn_addr_i[23:8] == match0_reg[23:8]);
  assign hit0 = break_ctl_reg[BRK_MATCH0_BIT] &&
                (break_ctl_reg[BRK_IGNLO0_BIT] ? hit_page : hit_full);
  assign step_hit  = break_ctl_reg[BRK_STEP_BIT];
  assign brk_event = cpu_insn_done_i && (hit0 || step_hit);

  // Command decode.
  logic       cmd_write; // Write-type command.
  logic [6:0] cmd_op;    // Operation index.
  logic       is_group;  // Register group access 0..7.
  logic       is_mem;    // Memory access at the program counter.
  logic       idle;      // Sequencer ready for a command.
  logic       go;        // Command accepted.
  logic [3:0] grp_sel;   // Group select after mode choice.
  assign cmd_write = wr.data[CMD_WRITE_BIT];
  assign cmd_op    = wr.data[6:0];
  assign is_group  = (cmd_op <= OP_LAST_GROUP);
  assign is_mem    = (cmd_op == OP_MEMORY);
  assign idle      = (state_reg == ST_IDLE);
  assign go        = wr_cmd && idle;
  // Stack pointer selection follows the core's current address mode.
  assign grp_sel = ((cmd_op == OP_SP) && !cpu_long_mode_i) ?
                   GRP_SP_SHORT : cmd_op[3:0];

  // Break control and match 0 bytes; a hardware break wins over a
  // simultaneous host write that tries to release it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      break_ctl_reg <= BREAK_CTL_RESET;
      match0_reg    <= 24'h000000;
    end else begin
      if (wr_brk) begin
        break_ctl_reg <= wr.data;
      end
      if (brk_event) begin
        break_ctl_reg[BRK_NEXT_BIT] <= 1'b1;
      end
      if (wr_m0u) begin
        match0_reg[23:16] <= wr.data;
      end
      if (wr_m0h) begin
        match0_reg[15:8] <= wr.data;
      end
      if (wr_m0l) begin
        match0_reg[7:0] <= wr.data;
      end
    end
  end

  // Master control: forced reset stays asserted until the core reports
  // the end of its reset; writing zero does not clear it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_reset_reg <= 1'b0;
      wake_reg        <= 1'b0;
    end else begin
      wake_reg <= wr_mst;
      if (wr_mst && wr.data[MASTER_RESET_BIT]) begin
        force_reset_reg <= 1'b1;
      end else if (cpu_reset_done_i) begin
        force_reset_reg <= 1'b0;
      end
    end
  end

  // Staging bytes; reset clears them although they hold only data.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_reg <= 24'h000000;
    end else begin
      if (wr_stu) begin
        stage_reg[23:16] <= wr.data;
      end
      if (wr_sth) begin
        stage_reg[15:8] <= wr.data;
      end
      if (wr_stl) begin
        stage_reg[7:0] <= wr.data;
      end
    end
  end

  // Sequencer: register reads take one cycle for the core to present
  // the group; memory accesses wait for the core's done.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go && is_group && !cmd_write) begin
          state_next = ST_RDREG;
        end else if (go && is_mem) begin
          state_next = ST_MEM;
        end
      end
      ST_RDREG: begin
        state_next = ST_IDLE;
      end
      ST_MEM: begin
        if (mem_done_i) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Pulses and select; unlisted or reserved codes raise nothing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg  <= ST_IDLE;
      sel_reg    <= 4'h0;
      reg_wr_reg <= 1'b0;
      set_reg    <= 1'b0;
      clr_reg    <= 1'b0;
      xchg_reg   <= 1'b0;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      pc_inc_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      reg_wr_reg <= go && is_group && cmd_write;
      set_reg    <= go && !cmd_write && (cmd_op == OP_LONG_SET);
      clr_reg    <= go && !cmd_write && (cmd_op == OP_LONG_CLR);
      xchg_reg   <= go && !cmd_write && (cmd_op == OP_EXCHANGE);
      mem_rd_reg <= go && is_mem && !cmd_write;
      mem_wr_reg <= go && is_mem && cmd_write;
      pc_inc_reg <= (state_reg == ST_MEM) && mem_done_i;
      if (go && is_group) begin
        sel_reg <= grp_sel;
      end
    end
  end

  // Read results: group read lands upper first; memory byte in low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= 24'h000000;
    end else if (state_reg == ST_RDREG) begin
      result_reg <= reg_rdata_i;
    end else if ((state_reg == ST_MEM) && mem_done_i &&
                 !mem_wr_o) begin
      result_reg <= {16'h0000, mem_rdata_i};
    end
  end

  // Memory direction is remembered while the access is outstanding.
  logic mem_is_wr_reg; // Outstanding access is a write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_is_wr_reg <= 1'b0;
    end else if (go && is_mem) begin
      mem_is_wr_reg <= cmd_write;
    end
  end

  // Outputs.
  assign break_o         = break_ctl_reg[BRK_NEXT_BIT];
  assign force_reset_o   = force_reset_reg;
  assign wake_o          = wake_reg;
  assign reg_sel_o       = sel_reg;
  assign reg_wr_o        = reg_wr_reg;
  assign reg_wdata_o     = stage_reg;
  assign long_mode_set_o = set_reg;
  assign long_mode_clr_o = clr_reg;
  assign exchange_o      = xchg_reg;
  assign mem_rd_o        = mem_rd_reg;
  assign mem_wr_o        = mem_is_wr_reg;
  // A single byte operand comes from the low staging byte.
  assign mem_wdata_o     = stage_reg[7:0];
  assign pc_inc_o        = pc_inc_reg;
  assign read_result_o   = result_reg;
  assign cmd_busy_o      = !idle;
endmodule : sdp_access_ctl
`default_nettype wire

// ---- sdp_access_ctl_asserts.sv ----
`default_nettype none
// Watches the processor side of the access block for timing slips.
module sdp_access_ctl_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cpu_reset_done_i,
  input wire logic        force_reset_o,
  input wire logic        wake_o,
  input wire logic        reg_wr_o,
  input wire logic [23:0] reg_rdata_i,
  input wire logic        long_mode_set_o,
  input wire logic        long_mode_clr_o,
  input wire logic        exchange_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic        mem_done_i,
  input wire logic [7:0]  mem_rdata_i,
  input wire logic        pc_inc_o,
  input wire logic [23:0] read_result_o,
  input wire logic        cmd_busy_o,
  input wire logic        break_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Everything here lives in the system domain, so one clocking will do.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A forced reset only starts together with a control write pulse.
  force_rise_a: assert property ($rose(force_reset_o) |-> wake_o)
    else $error("forced reset rose without a control write");
  // The forced reset holds until the core reports the end of reset.
  force_hold_a: assert property (
    force_reset_o && !cpu_reset_done_i |=> force_reset_o)
    else $error("forced reset dropped early");
  // It clears the cycle after the end of reset unless set again.
  force_clear_a: assert property (
    force_reset_o && cpu_reset_done_i |=> !force_reset_o || wake_o)
    else $error("forced reset did not clear itself");
  // A finished memory access advances the program counter next cycle.
  pc_follow_a: assert property (
    mem_done_i && cmd_busy_o |=> pc_inc_o && !cmd_busy_o)
    else $error("program counter not advanced after access");
  // The program counter only advances right after a memory access.
  pc_cause_a: assert property (pc_inc_o |-> $past(mem_done_i))
    else $error("program counter advanced without an access");
  // A memory read returns the byte with the upper bytes cleared.
  mem_result_a: assert property (
    mem_done_i && cmd_busy_o && !mem_wr_o
    |=> read_result_o == {16'h0000, $past(mem_rdata_i)})
    else $error("memory read result wrong");
  // A group read captures what the core offered in the busy cycle.
  group_read_a: assert property (
    $fell(cmd_busy_o) && !pc_inc_o |-> read_result_o == $past(reg_rdata_i))
    else $error("register read result wrong");
  // The result may only move when a command finishes.
  result_hold_a: assert property (
    $changed(read_result_o) |-> $fell(cmd_busy_o))
    else $error("read result changed without a command");
  // One command causes at most one kind of core action at a time.
  one_action_a: assert property ($onehot0({long_mode_set_o,
    long_mode_clr_o, exchange_o, reg_wr_o, mem_rd_o}))
    else $error("two core actions at once");
  cover property (reg_wr_o);
  cover property (pc_inc_o);
  cover property ($fell(force_reset_o));
  cover property (break_o);
endmodule // sdp_access_ctl_asserts
`default_nettype wire

// ---- sdp_host_model.sv ----
`default_nettype none
// Debug host: one register write per ready; idle lines show the inverse.
module sdp_host_model (
  input  wire logic       lnk_clk_i,
  input  wire logic       lnk_ready_i,
  output var  logic       lnk_wr_o,
  output var  logic [7:0] lnk_addr_o,
  output var  logic [7:0] lnk_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines start quiet so the link side sees no request before reset ends.
  initial begin
    lnk_wr_o = 1'b0;
    lnk_addr_o = 8'h00;
    lnk_data_o = 8'h00;
  end
  // Holds the request until it is taken, then waits for the acknowledge,
  // so the write pulse has reached the system domain when the task returns.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge lnk_clk_i);
    lnk_wr_o = 1'b1;
    lnk_addr_o = a;
    lnk_data_o = d;
    while (lnk_ready_i !== 1'b1) @(negedge lnk_clk_i);
    @(posedge lnk_clk_i);
    @(negedge lnk_clk_i);
    lnk_wr_o = 1'b0;
    lnk_addr_o = ~a;
    lnk_data_o = ~d;
    @(negedge lnk_clk_i);
    while (lnk_ready_i !== 1'b1) @(negedge lnk_clk_i);
  endtask
endmodule // sdp_host_model
`default_nettype wire

// ---- sdp_testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sdp_pkg::*;
  logic        clk_i, rst_i, lnk_clk_i, lnk_rst_i, lnk_wr_i, lnk_ready_o;
  logic [7:0]  lnk_addr_i, lnk_data_i, mem_wdata_o, mem_rdata_i, mwd;
  logic [23:0] cpu_insn_addr_i, reg_wdata_o, reg_rdata_i, read_result_o;
  logic [23:0] st, prev, l_wd;
  logic        cpu_insn_done_i, cpu_long_mode_i, cpu_reset_done_i, break_o;
  logic        force_reset_o, wake_o, reg_wr_o, long_mode_set_o, mw;
  logic        long_mode_clr_o, exchange_o, mem_rd_o, mem_wr_o, mem_done_i;
  logic        pc_inc_o, cmd_busy_o, mem_go;
  logic [3:0]  reg_sel_o, l_sel;
  int          cnt [7];      // Pulses seen: wr,set,clr,exch,mrd,inc,wake.
  int          snap [7];     // Pulse counts before a command.
  int          err_total, n_checks;
  // Row: code[15:8], long mode[7], pulse kind[6:4] (7 none), group[3:0].
  logic [15:0] rows [28] = '{16'h00F0, 16'h01F1, 16'h02F2, 16'h03F3,
    16'h04F4, 16'h05F5, 16'h06F6, 16'h0678, 16'h07F7, 16'h8080, 16'h8181,
    16'h8282, 16'h8383, 16'h8484, 16'h8585, 16'h8686, 16'h8608, 16'h8787,
    16'h0890, 16'h09A0, 16'h0AB0, 16'h03F3, 16'h88F0, 16'h89F0, 16'h8AF0,
    16'h0CF0, 16'h7FF0, 16'hFFF0};
  sdp_access_ctl i_sdp_access_ctl (.clk_i, .rst_i, .lnk_clk_i, .lnk_rst_i,
    .lnk_wr_i, .lnk_addr_i, .lnk_data_i, .lnk_ready_o, .cpu_insn_addr_i,
    .cpu_insn_done_i, .cpu_long_mode_i, .cpu_reset_done_i, .break_o,
    .force_reset_o, .wake_o, .reg_sel_o, .reg_wr_o, .reg_wdata_o,
    .reg_rdata_i, .long_mode_set_o, .long_mode_clr_o, .exchange_o,
    .mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_done_i, .mem_rdata_i,
    .pc_inc_o, .read_result_o, .cmd_busy_o);
  sdp_host_model i_sdp_host_model (.lnk_clk_i, .lnk_ready_i(lnk_ready_o),
    .lnk_wr_o(lnk_wr_i), .lnk_addr_o(lnk_addr_i), .lnk_data_o(lnk_data_i));
  // Core register groups answer with a pattern that names the group.
  function automatic logic [23:0] grp(input logic [3:0] s);
    return {4'h5, s, 8'hA5, 4'hC, s};
  endfunction
  assign reg_rdata_i = grp(reg_sel_o);
  // Two unrelated clocks: system 20 ns, link 32 ns.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    lnk_clk_i = 1'b0;
    #7;
    forever #16 lnk_clk_i = ~lnk_clk_i;
  end
  // Counts one-cycle pulses so each command's side effects can be tallied.
  always @(posedge clk_i) begin
    if (reg_wr_o === 1'b1) begin
      cnt[0]++;
      l_sel = reg_sel_o;
      l_wd = reg_wdata_o;
    end
    cnt[1] += int'(long_mode_set_o === 1'b1);
    cnt[2] += int'(long_mode_clr_o === 1'b1);
    cnt[3] += int'(exchange_o === 1'b1);
    cnt[4] += int'(mem_rd_o === 1'b1);
    cnt[5] += int'(pc_inc_o === 1'b1);
    cnt[6] += int'(wake_o === 1'b1);
  end
  // Core memory: finishes an expected access one cycle after it starts.
  always @(negedge clk_i) begin
    if (mem_go && cmd_busy_o === 1'b1 && !mem_done_i) begin
      mem_done_i <= 1'b1;
      mem_rdata_i <= 8'h7E;
      mem_go = 1'b0;
      mw = mem_wr_o;
      mwd = mem_wdata_o;
    end else begin
      mem_done_i <= 1'b0;
      mem_rdata_i <= 8'h81;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hw(input logic [7:0] a, input logic [7:0] d);
    i_sdp_host_model.wr(a, d);
    // The acknowledge can come back before the last pulse of a command
    // has been counted, so two system cycles pass before any check.
    repeat (2) @(negedge clk_i);
  endtask
  // Sets break control, which also releases any break, then runs one
  // instruction boundary at the given address.
  task automatic brk(input logic [23:0] a, input logic [7:0] c, input logic e);
    hw(ADDR_BREAK_CTL, c);
    @(negedge clk_i);
    cpu_insn_addr_i = a;
    cpu_insn_done_i = 1'b1;
    @(negedge clk_i);
    cpu_insn_done_i = 1'b0;
    cpu_insn_addr_i = ~a;
    @(negedge clk_i);
    chk(break_o, e);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // About 120 link writes near 0.2 us each; over ten times that is the limit.
  initial begin
    #300000;
    err_total++;
    end_of_test;
  end
  initial begin
    {rst_i, lnk_rst_i, mem_go} = 3'b110;
    {cpu_insn_done_i, cpu_long_mode_i, cpu_reset_done_i} = 3'b000;
    cpu_insn_addr_i = 24'h000000;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge lnk_clk_i);
    lnk_rst_i = 1'b0;
    chk({break_o, force_reset_o, cmd_busy_o, lnk_ready_o}, 4'h1);
    chk(read_result_o, 24'h000000);
    // Staging bytes then the command, as one ascending stream.
    foreach (rows[r]) begin
      @(negedge clk_i);
      cpu_long_mode_i = rows[r][7];
      st = {8'hA1, rows[r][15:8], ~rows[r][15:8]};
      hw(ADDR_STAGE_UPPER, st[23:16]);
      hw(ADDR_STAGE_HIGH, st[15:8]);
      hw(ADDR_STAGE_LOW, st[7:0]);
      snap = cnt;
      prev = read_result_o;
      hw(ADDR_COMMAND, rows[r][15:8]);
      for (int i = 0; i < 7; i++) begin
        chk(cnt[i] - snap[i], int'(rows[r][6:4] == i));
      end
      if (rows[r][6:4] == 3'h0) chk({l_sel, l_wd}, {rows[r][3:0], st});
      else if (rows[r][15:8] < 8'h08) chk(read_result_o, grp(rows[r][3:0]));
      else chk(read_result_o, prev);
    end
    // Memory read then write at the program counter.
    snap = cnt;
    mem_go = 1'b1;
    hw(ADDR_COMMAND, 8'h0B);
    chk(read_result_o, 24'h00007E);
    chk(cnt[4] - snap[4], 1);
    chk(cnt[5] - snap[5], 1);
    hw(ADDR_STAGE_LOW, 8'hC4);
    mem_go = 1'b1;
    hw(ADDR_COMMAND, 8'h8B);
    chk({mw, mwd}, 9'h1C4);
    chk(cnt[5] - snap[5], 2);
    // Match bytes give address 563412h.
    hw(ADDR_MATCH0_LOW, 8'h12);
    hw(ADDR_MATCH0_HIGH, 8'h34);
    hw(ADDR_MATCH0_UPPER, 8'h56);
    brk(24'h563413, 8'h08, 1'b0);
    brk(24'h563412, 8'h08, 1'b1);
    brk(24'h5634FF, 8'h0A, 1'b1);
    brk(24'h5635FF, 8'h0A, 1'b0);
    brk(24'h000000, 8'h01, 1'b1);
    brk(24'h563412, 8'h00, 1'b0);
    // Forced reset, its release, an unmapped write and a zero write.
    snap = cnt;
    hw(ADDR_MASTER_CTL, 8'h80);
    chk(force_reset_o, 1'b1);
    chk(cnt[6] - snap[6], 1);
    @(negedge clk_i);
    cpu_reset_done_i = 1'b1;
    @(negedge clk_i);
    cpu_reset_done_i = 1'b0;
    @(negedge clk_i);
    chk(force_reset_o, 1'b0);
    hw(8'h40, 8'h80);
    hw(ADDR_MASTER_CTL, 8'h00);
    chk(force_reset_o, 1'b0);
    chk(cnt[6] - snap[6], 2);
    end_of_test;
  end
endmodule // testbench
bind sdp_access_ctl sdp_access_ctl_asserts i_sdp_access_ctl_asserts (
  .clk_i, .rst_i, .cpu_reset_done_i, .force_reset_o, .wake_o, .reg_wr_o,
  .reg_rdata_i, .long_mode_set_o, .long_mode_clr_o, .exchange_o, .mem_rd_o,
  .mem_wr_o, .mem_done_i, .mem_rdata_i, .pc_inc_o, .read_result_o,
  .cmd_busy_o, .break_o);
`default_nettype wire
